/* File: design/asc_pkg.sv */
// Purpose: Shared constants and types for the serial converter core.
// Assumes: 125 MHz system clock, one clock domain.
// Notes:   Overview list below; field layout of the config word is fixed here.
//
// Overview of operation
// - Data taken on rising serial clock edges
// - Busy held low while operating, else high
// - Most significant bit first, both directions
// - Config in and result out shift together
// - New config acts only after next transfer
// - Oscillator halved internally for conversion timing
package asc_pkg;

	localparam int unsigned WORD_BITS = 16;

	// ----------------------------------------------------------------
	// Configuration word layout, MSB first on the wire
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       start_bit;
		logic [6:0] test_bits;
		logic [1:0] resolution;
		logic       offset_null;
		logic       gain_cal;
		logic       primary_power_down_bit;
		logic       secondary_power_down_bit;
		logic [1:0] spare_bits;
	} asc_cfg_t;

	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] OUT_RESET = 16'h0000;

	// Resolution codes and conversion lengths in 512 kHz ticks
	localparam logic [1:0]  RES_16 = 2'h0;
	localparam logic [1:0]  RES_14 = 2'h1;
	localparam logic [1:0]  RES_12 = 2'h2;
	localparam logic [1:0]  RES_10 = 2'h3;
	localparam logic [15:0] TICKS_RES_16 = 16'h2000;
	localparam logic [15:0] TICKS_RES_14 = 16'h0800;
	localparam logic [15:0] TICKS_RES_12 = 16'h0200;
	localparam logic [15:0] TICKS_RES_10 = 16'h0080;
	localparam logic [15:0] TICKS_CAL    = 16'h2000;

	// Pin sampling vector positions
	localparam int unsigned PIN_CS_N = 0;
	localparam int unsigned PIN_SCK  = 1;
	localparam int unsigned PIN_DIN  = 2;
	localparam int unsigned PIN_OSC  = 3;
	localparam int unsigned PIN_NUM  = 4;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_DOWN = 2'b10
	} asc_state_t;

	// Status seen by the surrounding logic
	typedef struct packed {
		asc_cfg_t   active_cfg;
		asc_cfg_t   pending_cfg;
		logic       converting;
		logic       shut_down;
	} asc_status_t;

endpackage

/* File: design/asc_pin_sync.sv */
// Purpose: Two-flop synchronisers with edge detection for the pins.
// Assumes: Inputs are asynchronous to clk_in.
// Notes:   Edges are taken from the second stage only.
`timescale 1ns/10ps
module asc_pin_sync
	import asc_pkg::*;
#(
	parameter int unsigned N = 4
) (
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	input  wire logic [N-1:0] pins_in,
	output logic      [N-1:0] level_out,
	output logic      [N-1:0] rise_out,
	output logic      [N-1:0] fall_out
);
	logic [N-1:0] meta_q;
	logic [N-1:0] level_q;
	logic [N-1:0] prev_q;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			meta_q  <= '0;
			level_q <= '0;
			prev_q  <= '0;
		end else begin
			meta_q  <= pins_in;
			level_q <= meta_q;
			prev_q  <= level_q;
		end
	end

	assign level_out = level_q;
	assign rise_out  = level_q & ~prev_q;
	assign fall_out  = ~level_q & prev_q;
endmodule // asc_pin_sync

/* File: design/asc_core.sv */
// Purpose: Serial configuration port and conversion timing of the converter.
// Assumes: Host drives select, clock and data; oscillator arrives on a pin.
// Notes:   Pins are oversampled; host bit rate must stay far below clk_in.
`timescale 1ns/10ps
module asc_core
	import asc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        cs_n_in,
	input  wire logic        sck_in,
	input  wire logic        din_in,
	input  wire logic        osc_in,
	input  wire logic [15:0] sample_in,
	output logic             dout_out,
	output logic             busy_n_out,
	output asc_status_t      status_out
);
	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	logic [PIN_NUM-1:0] pin_lvl;
	logic [PIN_NUM-1:0] pin_rise;
	logic [PIN_NUM-1:0] pin_fall;

	asc_pin_sync #(.N(PIN_NUM)) u_sync (
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.pins_in   ({osc_in, din_in, sck_in, cs_n_in}),
		.level_out (pin_lvl),
		.rise_out  (pin_rise),
		.fall_out  (pin_fall)
	);

	logic selected;
	logic sck_up;
	logic sck_down;
	logic end_xfer;
	assign selected = ~pin_lvl[PIN_CS_N];
	assign sck_up   = selected & pin_rise[PIN_SCK];
	assign sck_down = selected & pin_fall[PIN_SCK];

	// ----------------------------------------------------------------
	// Oscillator halving to the conversion tick
	// ----------------------------------------------------------------
	logic half_q;
	logic half_d;
	logic tick;

	always_comb begin
		half_d = half_q ^ pin_rise[PIN_OSC];
	end
	assign tick = pin_rise[PIN_OSC] & half_q;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			half_q <= 1'b0;
		end else begin
			half_q <= half_d;
		end
	end

	// ----------------------------------------------------------------
	// Shift path
	// ----------------------------------------------------------------
	logic [15:0] in_sr_q;
	logic [15:0] in_sr_d;
	logic [15:0] out_sr_q;
	logic [15:0] out_sr_d;
	logic [4:0]  bits_q;
	logic [4:0]  bits_d;
	logic        dout_q;
	logic        dout_d;
	logic [15:0] result_q;
	asc_cfg_t    pend_q;
	asc_cfg_t    pend_d;

	// Only a complete word counts; a short frame is discarded
	assign end_xfer = pin_rise[PIN_CS_N] & (bits_q == 5'(WORD_BITS));

	always_comb begin
		in_sr_d  = in_sr_q;
		out_sr_d = out_sr_q;
		bits_d   = bits_q;
		dout_d   = dout_q;
		pend_d   = pend_q;
		if (pin_fall[PIN_CS_N]) begin
			out_sr_d = result_q;
			dout_d   = result_q[15];
			bits_d   = 5'h00;
		end else if (sck_up) begin
			in_sr_d = {in_sr_q[14:0], pin_lvl[PIN_DIN]};
			if (bits_q != 5'(WORD_BITS)) begin
				bits_d = bits_q + 5'h01;
			end
		end else if (sck_down) begin
			out_sr_d = {out_sr_q[14:0], 1'b0};
			dout_d   = out_sr_q[14];
		end
		if (end_xfer) begin
			pend_d = asc_cfg_t'(in_sr_q);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			in_sr_q  <= CFG_RESET;
			out_sr_q <= OUT_RESET;
			bits_q   <= 5'h00;
			dout_q   <= 1'b0;
			pend_q   <= asc_cfg_t'(CFG_RESET);
		end else begin
			in_sr_q  <= in_sr_d;
			out_sr_q <= out_sr_d;
			bits_q   <= bits_d;
			dout_q   <= dout_d;
			pend_q   <= pend_d;
		end
	end

	// ----------------------------------------------------------------
	// Conversion control
	// ----------------------------------------------------------------
	function automatic logic [15:0] conv_len(input asc_cfg_t c);
		if (c.offset_null || c.gain_cal) begin
			conv_len = TICKS_CAL;
		end else begin
			case (c.resolution)
				RES_16:  conv_len = TICKS_RES_16;
				RES_14:  conv_len = TICKS_RES_14;
				RES_12:  conv_len = TICKS_RES_12;
				default: conv_len = TICKS_RES_10;
			endcase
		end
	endfunction

	asc_state_t  st_q;
	asc_state_t  st_d;
	asc_cfg_t    act_q;
	asc_cfg_t    act_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic [15:0] result_d;
	logic        busy_n_q;
	logic        busy_n_d;

	always_comb begin
		st_d     = st_q;
		act_d    = act_q;
		cnt_d    = cnt_q;
		result_d = result_q;
		busy_n_d = busy_n_q;
		case (st_q)
			ST_IDLE, ST_DOWN: begin
				busy_n_d = 1'b1;
			end
			ST_CONV: begin
				busy_n_d = 1'b0;
				if (tick) begin
					if (cnt_q <= 16'h0001) begin
						st_d     = ST_IDLE;
						busy_n_d = 1'b1;
						// Calibration cycles leave the last result alone
						if (!act_q.offset_null && !act_q.gain_cal) begin
							result_d = sample_in;
						end
					end else begin
						cnt_d = cnt_q - 16'h0001;
					end
				end
			end
			default: begin
				st_d     = ST_IDLE;
				busy_n_d = 1'b1;
			end
		endcase
		// Word that was pending before this frame takes over now
		if (end_xfer) begin
			act_d = pend_q;
			cnt_d = conv_len(pend_q);
			if (pend_q.primary_power_down_bit || pend_q.secondary_power_down_bit) begin
				st_d     = ST_DOWN;
				busy_n_d = 1'b1;
			end else begin
				st_d     = ST_CONV;
				busy_n_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			st_q     <= ST_IDLE;
			act_q    <= asc_cfg_t'(CFG_RESET);
			cnt_q    <= 16'h0000;
			result_q <= OUT_RESET;
			busy_n_q <= 1'b1;
		end else begin
			st_q     <= st_d;
			act_q    <= act_d;
			cnt_q    <= cnt_d;
			result_q <= result_d;
			busy_n_q <= busy_n_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	asc_status_t status_q;
	asc_status_t status_d;

	always_comb begin
		status_d.active_cfg  = act_d;
		status_d.pending_cfg = pend_d;
		status_d.converting  = (st_d == ST_CONV);
		status_d.shut_down   = (st_d == ST_DOWN);
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			status_q <= '0;
		end else begin
			status_q <= status_d;
		end
	end

	assign dout_out   = dout_q;
	assign busy_n_out = busy_n_q;
	assign status_out = status_q;
endmodule // asc_core

/* File: testbench/asc_core_monitor.sv */
// Purpose: Port-level protocol checks for asc_core.
// Assumes: Pin changes reach logic 3 edges late; outputs registered.
// Notes:   Bound to every asc_core instance.
`timescale 1ns/10ps
module asc_core_monitor
	import asc_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rstn_in,
	input wire logic        cs_n_in,
	input wire logic        sck_in,
	input wire logic        din_in,
	input wire logic        osc_in,
	input wire logic [15:0] sample_in,
	input wire logic        dout_out,
	input wire logic        busy_n_out,
	input asc_status_t      status_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_busy_tracks_conv: assert property (busy_n_out == !status_out.converting)
		else $error("busy and converting disagree");
	a_busy_after_end: assert property ($fell(busy_n_out) |->
		$past(cs_n_in, 3) && !$past(cs_n_in, 4)) else $error("busy fell without frame end");
	a_down_not_busy: assert property (status_out.shut_down |-> busy_n_out)
		else $error("busy while shut down");
	a_dout_cause: assert property ($changed(dout_out) |->
		(!$past(sck_in, 3) && $past(sck_in, 4)) || (!$past(cs_n_in, 3) && $past(cs_n_in, 4)))
		else $error("dout moved without clock fall");
	a_active_from_pend: assert property ($changed(status_out.active_cfg) |->
		status_out.active_cfg == $past(status_out.pending_cfg)) else $error("bad active word");
	a_pend_at_end: assert property ($changed(status_out.pending_cfg) |->
		$past(cs_n_in, 3) && !$past(cs_n_in, 4)) else $error("pending moved mid frame");
	a_hold_in_frame: assert property ((!cs_n_in && !$past(cs_n_in, 4)) |->
		$stable(status_out.active_cfg)) else $error("active moved while selected");
	a_down_needs_bit: assert property ($rose(status_out.shut_down) |->
		status_out.active_cfg.primary_power_down_bit
		|| status_out.active_cfg.secondary_power_down_bit) else $error("shut down without bit");
	c_conv: cover property ($fell(busy_n_out));
	c_down: cover property ($rose(status_out.shut_down));
	c_act: cover property ($changed(status_out.active_cfg));
endmodule // asc_core_monitor

bind asc_core asc_core_monitor u_asc_core_monitor (.clk_in(clk_in), .rstn_in(rstn_in),
	.cs_n_in(cs_n_in), .sck_in(sck_in), .din_in(din_in), .osc_in(osc_in),
	.sample_in(sample_in), .dout_out(dout_out), .busy_n_out(busy_n_out),
	.status_out(status_out));

/* File: testbench/asc_host_model.sv */
// Purpose: Host side of the serial link.
// Assumes: Bit time scaled to 16 system clocks.
// Notes:   Released data line shows the inverse of its last bit.
`timescale 1ns/10ps
module asc_host_model (
	input  wire logic clk_in,
	input  wire logic dout_in,
	output logic      cs_n_out,
	output logic      sck_out,
	output logic      din_out
);
	initial begin
		cs_n_out = 1'b1;
		sck_out  = 1'b0;
		din_out  = 1'b0;
	end
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
		r = 16'h0000;
		@(negedge clk_in);
		sck_out = 1'b0;
		cs_n_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			din_out = w[15-i];
			repeat (8) @(negedge clk_in);
			sck_out = 1'b1;
			repeat (8) @(negedge clk_in);
			r = {r[14:0], dout_in};
			sck_out = 1'b0;
		end
		repeat (8) @(negedge clk_in);
		cs_n_out = 1'b1;
		din_out = ~din_out;
		repeat (8) @(negedge clk_in);
	endtask
endmodule // asc_host_model

/* File: testbench/asc_core_tb.sv */
// Purpose: Self-checking bench for asc_core.
// Assumes: Oscillator at half of clk_in keeps conversions short.
// Notes:   First conversion runs 16-bit from the reset word.
`timescale 1ns/10ps
module asc_core_tb import asc_pkg::*;;
	logic        clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic        osc_in = 1'b0;
	logic [15:0] sample_in = 16'h0000;
	logic        cs_n, sck, din, dout_out, busy_n_out;
	asc_status_t status_out;
	logic [15:0] r;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          c;
	always #4 clk_in = ~clk_in;
	always #8 osc_in = ~osc_in;
	asc_core u_asc_core (.clk_in(clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n), .sck_in(sck),
		.din_in(din), .osc_in(osc_in), .sample_in(sample_in), .dout_out(dout_out),
		.busy_n_out(busy_n_out), .status_out(status_out));
	asc_host_model u_asc_host_model (.clk_in(clk_in), .dout_in(dout_out), .cs_n_out(cs_n),
		.sck_out(sck), .din_out(din));
	task automatic test_done();
		if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Wide enough for both output bits plus the whole status word
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Cycles until busy releases, bounded
	task automatic wait_busy(input int lim, output int cnt);
		cnt = 0;
		while (busy_n_out !== 1'b1) begin
			@(negedge clk_in);
			cnt++;
			if (cnt > lim) begin
				n_errors++;
				test_done();
			end
		end
	endtask
	initial begin
		repeat (12) @(negedge clk_in);
		rstn_in = 1'b1;
		chk({dout_out, busy_n_out, status_out}, {2'h1, 34'h0});
		repeat (4) @(negedge clk_in);
		u_asc_host_model.xfer(16'h80C0, 16, r);
		chk(r, 16'h0000);
		chk(status_out, {16'h0000, 16'h80C0, 2'h2});
		chk(busy_n_out, 1'b0);
		sample_in = 16'h1234;
		wait_busy(70000, c);
		u_asc_host_model.xfer(16'h80C8, 16, r);
		chk(r, 16'h1234);
		sample_in = 16'hA5C3;
		wait_busy(2000, c);
		// 10-bit word: 0x80 ticks of four clocks, less the frame tail
		chk(c >= 496 && c <= 512, 1'b1);
		u_asc_host_model.xfer(16'hFFFF, 8, r);
		chk(status_out, {16'h80C0, 16'h80C8, 2'h0});
		u_asc_host_model.xfer(16'h80C0, 16, r);
		chk(r, 16'hA5C3);
		chk({busy_n_out, status_out}, {1'b1, 16'h80C8, 16'h80C0, 2'h1});
		u_asc_host_model.xfer(16'h80C0, 16, r);
		chk(r, 16'hA5C3);
		chk(status_out, {16'h80C0, 16'h80C0, 2'h2});
		wait_busy(2000, c);
		u_asc_host_model.xfer(16'h8C8C, 16, r);
		u_asc_host_model.xfer(16'h8C88, 16, r);
		u_asc_host_model.xfer(16'h8C80, 16, r);
		chk(status_out, {16'h8C88, 16'h8C80, 2'h1});
		test_done();
	end
endmodule // asc_core_tb
